// File: src/oau_top.sv
`timescale 1ns/1ns
module oau_top (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic start_i,
	input wire oau_pkg::oau_instr_t instr_i,
	input wire logic [15:0] instr_ptr_i,
	input wire logic [15:0] src_reg_val_i,
	input wire logic [15:0] dst_reg_val_i,
	input wire logic mem_ack_i,
	input wire logic [15:0] mem_rdata_i,
	input wire logic wb_en_i,
	input wire logic [15:0] wb_value_i,
	output oau_pkg::oau_mreq_t mem_o,
	output logic busy_o,
	output oau_pkg::oau_result_t result_o,
	output logic [15:0] instr_ptr_o,
	output logic ptr_we_o,
	output logic [3:0] ptr_reg_o,
	output logic [15:0] ptr_val_o,
	output logic reg_we_o,
	output logic [15:0] reg_wdata_o,
	output oau_pkg::oau_flags_t flags_o
);
	import oau_pkg::*;

	// ----------------------------------------
	// State and storage
	// ----------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_SEXT = 6'b000010,
		ST_SOP = 6'b000100,
		ST_DEXT = 6'b001000,
		ST_DONE = 6'b010000,
		ST_HOLD = 6'b100000
	} oau_state_t;

	oau_state_t state;
	oau_state_t next_state;
	oau_instr_t ins;
	logic [15:0] ptr;
	logic [15:0] sbase;
	logic [15:0] dbase;
	logic [15:0] saddr;
	logic [15:0] sval;
	logic [15:0] daddr;
	oau_mreq_t mem;
	oau_result_t res;
	logic pwe;
	logic [15:0] pval;
	logic rwe;
	logic [15:0] rdat;
	oau_flags_t flg;
	logic busy;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Base value seen by indexed modes
	function automatic logic [15:0] base_of(input logic [3:0] r, input logic [15:0] v, input logic [15:0] p);
		logic [15:0] b;
		b = v;
		if (r == OAU_REG_IPTR)
			b = p;
		if (r == OAU_REG_FLAG)
			b = OAU_RESET_WORD;
		return b;
	endfunction

	// ----------------------------------------
	// Decode of the incoming and the latched instruction
	// ----------------------------------------
	wire cg_hit;
	wire [15:0] cg_val;
	oau_flags_t next_flg;

	oau_cgen u_cgen (
		.reg_i(instr_i.src_reg),
		.mode_i(instr_i.source_mode_field),
		.hit_o(cg_hit),
		.value_o(cg_val)
	);

	oau_byte_flags u_flags (
		.value_i(wb_value_i),
		.byte_i(ins.byte_op),
		.flags_o(next_flg)
	);

	wire in_src_idx = (instr_i.source_mode_field == OAU_AS_IDX) && !cg_hit;
	wire in_src_mem = instr_i.source_mode_field[1] && !cg_hit;
	wire in_src_imm = (instr_i.source_mode_field == OAU_AS_INC) && (instr_i.src_reg == OAU_REG_IPTR);
	// destination bit is register or indexed
	wire in_dst_idx = instr_i.dst_mode;
	wire [15:0] in_sbase = base_of(instr_i.src_reg, src_reg_val_i, instr_ptr_i);
	wire [15:0] in_dbase = base_of(instr_i.dst_reg, dst_reg_val_i, instr_ptr_i);
	wire cur_inc = (ins.source_mode_field == OAU_AS_INC);
	wire [15:0] step = ins.byte_op ? OAU_STEP_BYTE : OAU_STEP_WORD;
	wire [15:0] ptr_next = ptr + OAU_STEP_WORD;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// any pairing flows through chain
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (start_i) begin
					if (in_src_idx)
						next_state = ST_SEXT;
					else if (in_src_mem)
						next_state = ST_SOP;
					else if (in_dst_idx)
						next_state = ST_DEXT;
					else
						next_state = ST_DONE;
				end
			end
			ST_SEXT: begin
				if (mem_ack_i)
					next_state = ST_SOP;
			end
			ST_SOP: begin
				if (mem_ack_i)
					next_state = ins.dst_mode ? ST_DEXT : ST_DONE;
			end
			ST_DEXT: begin
				if (mem_ack_i)
					next_state = ST_DONE;
			end
			ST_DONE: begin
				next_state = ST_HOLD;
			end
			ST_HOLD: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Memory request decode
	// ----------------------------------------
	// Source operand address once the offset word is in
	wire [15:0] sext_addr = sbase + mem_rdata_i;
	// Immediate source consumes the word at the pointer
	wire cur_imm = cur_inc && (ins.src_reg == OAU_REG_IPTR);
	// Offset word of the source sits at the pointer
	wire [15:0] sext_ptr = (state == ST_IDLE) ? instr_ptr_i : ptr;
	// Pointer at the destination offset word, past any immediate
	wire [15:0] dext_ptr = (state == ST_IDLE) ? instr_ptr_i :
		(state == ST_SOP && cur_imm) ? ptr_next : ptr;
	wire [15:0] sop_addr = (state == ST_IDLE) ? (in_src_imm ? instr_ptr_i : src_reg_val_i) :
		(state == ST_SEXT) ? sext_addr : saddr;

	// Request for the cycle after this edge
	wire [15:0] next_maddr = (next_state == ST_SEXT) ? sext_ptr :
		(next_state == ST_SOP) ? sop_addr : dext_ptr;
	wire next_mreq = (next_state == ST_SEXT) || (next_state == ST_SOP) || (next_state == ST_DEXT);

	// ----------------------------------------
	// Sequence strobes
	// ----------------------------------------
	// Instruction taken while idle
	wire take = (state == ST_IDLE) && start_i;
	// Memory answers per phase
	wire sext_ack = (state == ST_SEXT) && mem_ack_i;
	wire sop_ack = (state == ST_SOP) && mem_ack_i;
	wire dext_ack = (state == ST_DEXT) && mem_ack_i;
	// Last cycle before the destination offset fetch
	wire dext_enter = (next_state == ST_DEXT) && (state != ST_DEXT);

	// ----------------------------------------
	// Next values of the sequencer registers
	// ----------------------------------------
	// register zero tracks pointer
	wire [15:0] next_ptr = take ? instr_ptr_i :
		dext_enter ? dext_ptr :
		(sext_ack || dext_ack || (sop_ack && cur_imm)) ? ptr_next : ptr;
	// signed offset wraps modulo 16 bits
	wire [15:0] next_saddr = (take || sext_ack) ? sop_addr : saddr;
	wire [15:0] sop_data = ins.byte_op ? (mem_rdata_i & OAU_BYTE_MASK) : mem_rdata_i;
	wire [15:0] next_sval = take ? (cg_hit ? cg_val : src_reg_val_i) :
		sop_ack ? sop_data : sval;
	wire [15:0] dext_base = (ins.dst_reg == OAU_REG_IPTR) ? ptr : dbase;
	wire [15:0] next_daddr = dext_ack ? (dext_base + mem_rdata_i) : daddr;

	// ----------------------------------------
	// Sequencer registers
	// ----------------------------------------
	// State and busy flag
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			state <= ST_IDLE;
			busy <= 1'b0;
		end else begin
			state <= next_state;
			busy <= (next_state != ST_IDLE);
		end
	end

	// Memory request, held until the answer
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			mem <= '0;
		end else begin
			mem.req <= next_mreq;
			mem.addr <= next_maddr;
		end
	end

	// Latched instruction and base values
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			ins <= '0;
			sbase <= OAU_RESET_WORD;
			dbase <= OAU_RESET_WORD;
		end else if (take) begin
			ins <= instr_i;
			sbase <= in_sbase;
			dbase <= in_dbase;
		end
	end

	// Pointer register
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			ptr <= OAU_RESET_WORD;
		end else begin
			ptr <= next_ptr;
		end
	end

	// Operand address and value registers
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			saddr <= OAU_RESET_WORD;
			sval <= OAU_RESET_WORD;
			daddr <= OAU_RESET_WORD;
		end else begin
			saddr <= next_saddr;
			sval <= next_sval;
			daddr <= next_daddr;
		end
	end

	// ----------------------------------------
	// Outputs toward core
	// ----------------------------------------
	// step of one or two
	wire next_pwe = sop_ack && cur_inc && (ins.src_reg != OAU_REG_IPTR);
	wire [15:0] next_pval = saddr + step;
	wire [15:0] next_rdat = ins.byte_op ? (wb_value_i & OAU_BYTE_MASK) : wb_value_i;

	// Operand result, valid for one cycle
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			res <= '0;
		end else begin
			res.valid <= (state == ST_DONE);
			res.src_val <= sval;
			res.dst_addr <= daddr;
			res.dst_is_reg <= !ins.dst_mode;
			res.dst_reg <= ins.dst_reg;
			res.byte_op <= ins.byte_op;
		end
	end

	// Pointer write-back of the autoincrement
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			pwe <= 1'b0;
			pval <= OAU_RESET_WORD;
		end else begin
			pwe <= next_pwe;
			pval <= next_pval;
		end
	end

	// Register write data and byte-aware flags
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			rwe <= 1'b0;
			rdat <= OAU_RESET_WORD;
			flg <= '0;
		end else begin
			rwe <= wb_en_i;
			rdat <= next_rdat;
			if (wb_en_i)
				flg <= next_flg;
		end
	end

	// ----------------------------------------
	// Port drive
	// ----------------------------------------
	assign mem_o = mem;
	assign busy_o = busy;
	assign result_o = res;
	assign instr_ptr_o = ptr;
	assign ptr_we_o = pwe;
	assign ptr_reg_o = ins.src_reg;
	assign ptr_val_o = pval;
	assign reg_we_o = rwe;
	assign reg_wdata_o = rdat;
	assign flags_o = flg;
endmodule

// File: include/oau_pkg.sv
package oau_pkg;

	// ----------------------------------------
	// Widths and register numbers
	// ----------------------------------------
	localparam int OAU_DW = 16;
	localparam logic [3:0] OAU_REG_IPTR = 4'h0;
	localparam logic [3:0] OAU_REG_FLAG = 4'h2;
	localparam logic [3:0] OAU_REG_CG2 = 4'h3;

	// Source mode codes
	localparam logic [1:0] OAU_AS_REG = 2'h0;
	localparam logic [1:0] OAU_AS_IDX = 2'h1;
	localparam logic [1:0] OAU_AS_IND = 2'h2;
	localparam logic [1:0] OAU_AS_INC = 2'h3;

	// Pointer steps and constant generator values
	localparam logic [15:0] OAU_STEP_BYTE = 16'h0001;
	localparam logic [15:0] OAU_STEP_WORD = 16'h0002;
	localparam logic [15:0] OAU_CG_ZERO = 16'h0000;
	localparam logic [15:0] OAU_CG_ONE = 16'h0001;
	localparam logic [15:0] OAU_CG_TWO = 16'h0002;
	localparam logic [15:0] OAU_CG_FOUR = 16'h0004;
	localparam logic [15:0] OAU_CG_EIGHT = 16'h0008;
	localparam logic [15:0] OAU_CG_MONE = 16'hFFFF;
	localparam logic [15:0] OAU_BYTE_MASK = 16'h00FF;
	localparam logic [15:0] OAU_RESET_WORD = 16'h0000;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [3:0] src_reg;
		logic [1:0] source_mode_field;
		logic dst_mode;
		logic [3:0] dst_reg;
		logic byte_op;
	} oau_instr_t;

	typedef struct packed {
		logic req;
		logic [15:0] addr;
	} oau_mreq_t;

	typedef struct packed {
		logic valid;
		logic [15:0] src_val;
		logic [15:0] dst_addr;
		logic dst_is_reg;
		logic [3:0] dst_reg;
		logic byte_op;
	} oau_result_t;

	typedef struct packed {
		logic n;
		logic z;
	} oau_flags_t;

endpackage

// File: src/oau_cgen.sv
`timescale 1ns/1ns
module oau_cgen (
	input wire logic [3:0] reg_i,
	input wire logic [1:0] mode_i,
	output logic hit_o,
	output logic [15:0] value_o
);
	import oau_pkg::*;

	// ----------------------------------------
	// Constant generator decode
	// ----------------------------------------
	// no extension word needed
	wire is_flag = (reg_i == OAU_REG_FLAG) && (mode_i[1] == 1'b1);
	wire is_cg2 = (reg_i == OAU_REG_CG2);
	assign hit_o = is_flag || is_cg2;
	assign value_o = is_flag ? (mode_i[0] ? OAU_CG_EIGHT : OAU_CG_FOUR) :
		(mode_i == OAU_AS_REG) ? OAU_CG_ZERO :
		(mode_i == OAU_AS_IDX) ? OAU_CG_ONE :
		(mode_i == OAU_AS_IND) ? OAU_CG_TWO : OAU_CG_MONE;
endmodule

// File: src/oau_byte_flags.sv
`timescale 1ns/1ns
module oau_byte_flags (
	input wire logic [15:0] value_i,
	input wire logic byte_i,
	output oau_pkg::oau_flags_t flags_o
);
	import oau_pkg::*;

	// ----------------------------------------
	// Width aware sign and zero
	// ----------------------------------------
	// byte flags from low byte
	assign flags_o.n = byte_i ? value_i[7] : value_i[15];
	assign flags_o.z = byte_i ? (value_i[7:0] == 8'h00) : (value_i == OAU_RESET_WORD);
endmodule

// File: verif/oau_monitor.sv
`timescale 1ns/1ns
module oau_monitor (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic start_i,
	input wire oau_pkg::oau_instr_t instr_i,
	input wire logic [15:0] instr_ptr_i,
	input wire logic [15:0] src_reg_val_i,
	input wire logic mem_ack_i,
	input wire logic wb_en_i,
	input wire logic [15:0] wb_value_i,
	input wire oau_pkg::oau_mreq_t mem_o,
	input wire logic busy_o,
	input wire oau_pkg::oau_result_t result_o,
	input wire logic ptr_we_o,
	input wire logic [3:0] ptr_reg_o,
	input wire logic [15:0] ptr_val_o,
	input wire logic reg_we_o,
	input wire logic [15:0] reg_wdata_o,
	input wire oau_pkg::oau_flags_t flags_o
);
	import oau_pkg::*;
	logic bq;
	logic [3:0] rq;
	logic [15:0] vq;
	wire logic go = start_i && !busy_o;
	wire logic [1:0] md = instr_i.source_mode_field;
	// Capture of the accepted instruction
	always_ff @(posedge core_clk_i) begin
		if (go) begin
			bq <= instr_i.byte_op;
			rq <= instr_i.src_reg;
			vq <= src_reg_val_i;
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	property p_req_hold;
		mem_o.req && !mem_ack_i |=> mem_o.req && $stable(mem_o.addr);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped early");
	property p_req_busy;
		mem_o.req |-> busy_o;
	endproperty
	a_req_busy: assert property (p_req_busy) else $error("request while idle");
	property p_reg_nofetch;
		go && md == OAU_AS_REG && !instr_i.dst_mode |=> !mem_o.req ##1 result_o.valid;
	endproperty
	a_reg_nofetch: assert property (p_reg_nofetch) else $error("register mode fetched");
	property p_idx_ext;
		go && md == OAU_AS_IDX && instr_i.src_reg != OAU_REG_CG2
		|=> mem_o.req && mem_o.addr == $past(instr_ptr_i);
	endproperty
	a_idx_ext: assert property (p_idx_ext) else $error("offset word not fetched first");
	property p_ind_addr;
		go && md == OAU_AS_IND && instr_i.src_reg > OAU_REG_CG2
		|=> mem_o.req && mem_o.addr == $past(src_reg_val_i);
	endproperty
	a_ind_addr: assert property (p_ind_addr) else $error("indirect address wrong");
	property p_imm_addr;
		go && md == OAU_AS_INC && instr_i.src_reg == OAU_REG_IPTR
		|=> mem_o.req && mem_o.addr == $past(instr_ptr_i);
	endproperty
	a_imm_addr: assert property (p_imm_addr) else $error("immediate address wrong");
	property p_inc_step;
		ptr_we_o |-> ptr_reg_o == rq && ptr_val_o == vq + (bq ? OAU_STEP_BYTE : OAU_STEP_WORD);
	endproperty
	a_inc_step: assert property (p_inc_step) else $error("pointer step wrong");
	property p_byte_mask;
		wb_en_i |=> reg_we_o && reg_wdata_o == (bq ? $past(wb_value_i) & OAU_BYTE_MASK : $past(wb_value_i));
	endproperty
	a_byte_mask: assert property (p_byte_mask) else $error("write data not masked");
	property p_byte_flags;
		wb_en_i |=> flags_o.n == (bq ? $past(wb_value_i[7]) : $past(wb_value_i[15]));
	endproperty
	a_byte_flags: assert property (p_byte_flags) else $error("negative flag wrong");
	c_idx: cover property (go && md == OAU_AS_IDX);
	c_inc: cover property (ptr_we_o);
	c_byte: cover property (wb_en_i && bq);
endmodule

// File: verif/oau_mem_model.sv
`timescale 1ns/1ns
module oau_mem_model (
	input wire logic clk_i,
	input wire oau_pkg::oau_mreq_t mem_i,
	input wire logic [1:0] wait_i,
	output logic ack_o,
	output logic [15:0] rdata_o
);
	logic [1:0] cnt = 2'h0;
	initial ack_o = 1'b0;
	initial rdata_o = 16'h0000;
	// Answer after wait_i cycles; data is the byte-swapped address
	always @(negedge clk_i) begin
		if (ack_o || !mem_i.req) begin
			ack_o <= 1'b0;
			rdata_o <= ~rdata_o;
			cnt <= 2'h0;
		end else if (cnt == wait_i) begin
			ack_o <= 1'b1;
			rdata_o <= {mem_i.addr[7:0], mem_i.addr[15:8]};
		end else begin
			cnt <= cnt + 2'h1;
			rdata_o <= ~rdata_o;
		end
	end
endmodule

// File: verif/operand_addressing_unit_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module operand_addressing_unit_tb_top;
	import oau_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, wb_en = 1'b0, ack, seen, pw, pwe, busy, rwe;
	logic [1:0] mw = 2'h0;
	logic [15:0] ptr = 16'h0000, sv = 16'h0000, dv = 16'h0000, wv = 16'h0000, rd, ip, pv, pval, wd, iq;
	logic [3:0] preg;
	oau_instr_t ins = '0;
	oau_mreq_t mem;
	oau_result_t res, r;
	oau_flags_t fl;
	int fail_count = 0, n_tests = 0;
	oau_top dut_u (.core_clk_i(clk), .rstn_i(rst_n), .start_i(start), .instr_i(ins), .instr_ptr_i(ptr),
		.src_reg_val_i(sv), .dst_reg_val_i(dv), .mem_ack_i(ack), .mem_rdata_i(rd), .wb_en_i(wb_en),
		.wb_value_i(wv), .mem_o(mem), .busy_o(busy), .result_o(res), .instr_ptr_o(iq), .ptr_we_o(pwe),
		.ptr_reg_o(preg), .ptr_val_o(pval), .reg_we_o(rwe), .reg_wdata_o(wd), .flags_o(fl));
	oau_mem_model mem_u (.clk_i(clk), .mem_i(mem), .wait_i(mw), .ack_o(ack), .rdata_o(rd));
	initial forever #2 clk = ~clk;
	function automatic logic [15:0] sw(input logic [15:0] a);
		return {a[7:0], a[15:8]};
	endfunction
	function automatic oau_instr_t mk(input logic [3:0] a, input logic [1:0] m, input logic e, input logic y);
		return '{a, m, e, 4'h6, y};
	endfunction
	// One instruction, watched until idle again
	task automatic issue(input oau_instr_t i, input logic [15:0] p, input logic [15:0] s);
		int k;
		@(negedge clk);
		start = 1'b1;
		ins = i;
		ptr = p;
		sv = s;
		dv = 16'h0300;
		@(negedge clk);
		start = 1'b0;
		seen = 1'b0;
		pw = 1'b0;
		for (k = 0; k < 40 && !(seen && busy === 1'b0); k++) begin
			if (pwe === 1'b1) begin
				pw = 1'b1;
				pv = pval;
			end
			if (res.valid === 1'b1) begin
				seen = 1'b1;
				r = res;
			end
			@(negedge clk);
		end
		ip = iq;
		`CHK(seen, 1'b1)
		`CHK(r.dst_reg, 4'h6)
		`CHK(r.byte_op, i.byte_op)
	endtask
	task t_reg;
		issue(mk(4'h5, OAU_AS_REG, 1'b0, 1'b0), 16'hFF14, 16'hA023);
		`CHK(r.src_val, 16'hA023)
		`CHK(r.dst_is_reg, 1'b1)
		`CHK(pw, 1'b0)
		`CHK(ip, 16'hFF14)
	endtask
	task t_idx;
		mw = 2'h2;
		issue(mk(4'h5, OAU_AS_IDX, 1'b1, 1'b0), 16'h1000, 16'h0200);
		`CHK(r.src_val, sw(16'h0200 + sw(16'h1000)))
		`CHK(r.dst_addr, 16'h0300 + sw(16'h1002))
		`CHK(ip, 16'h1004)
		mw = 2'h0;
	endtask
	task t_sym;
		issue(mk(4'h0, OAU_AS_IDX, 1'b1, 1'b0), 16'hF012, 16'hF012);
		`CHK(r.src_val, sw(16'hF012 + sw(16'hF012)))
		`CHK(ip, 16'hF016)
	endtask
	task t_abs;
		issue(mk(4'h2, OAU_AS_IDX, 1'b1, 1'b0), 16'h2000, 16'hBEEF);
		`CHK(r.src_val, 16'h2000)
		`CHK(r.dst_is_reg, 1'b0)
	endtask
	task t_ind;
		issue(mk(4'h7, OAU_AS_IND, 1'b0, 1'b1), 16'h4000, 16'h0FA2);
		`CHK(r.src_val, sw(16'h0FA2) & OAU_BYTE_MASK)
		`CHK(pw, 1'b0)
	endtask
	task t_inc;
		for (int b = 0; b < 2; b++) begin
			mw = 2'h3;
			issue(mk(4'h8, OAU_AS_INC, 1'b0, b[0]), 16'h4000, 16'h0FA0);
			`CHK(pv, b ? 16'h0FA1 : 16'h0FA2)
			`CHK(r.src_val, b ? 16'h000F : 16'hA00F)
		end
		mw = 2'h0;
	endtask
	task t_imm;
		issue(mk(4'h0, OAU_AS_INC, 1'b1, 1'b0), 16'hFF14, 16'hFF14);
		`CHK(r.src_val, sw(16'hFF14))
		`CHK(r.dst_addr, 16'h0300 + sw(16'hFF16))
		`CHK(ip, 16'hFF18)
	endtask
	task t_cg;
		logic [15:0] cg [6] = '{16'h0000, 16'h0001, 16'h0002, 16'hFFFF, 16'h0004, 16'h0008};
		for (int k = 0; k < 6; k++) begin
			issue(mk(k < 4 ? 4'h3 : 4'h2, k < 4 ? k[1:0] : k[1:0] + 2'h2, 1'b0, 1'b0), 16'h5000, 16'h1111);
			`CHK(r.src_val, cg[k])
			`CHK(ip, 16'h5000)
		end
	endtask
	task automatic t_wb(input logic b, input logic [15:0] v, input logic [15:0] e, input logic n, input logic z);
		issue(mk(4'h5, OAU_AS_REG, 1'b0, b), 16'h6000, v);
		wv = v;
		wb_en = 1'b1;
		@(negedge clk);
		wb_en = 1'b0;
		`CHK(rwe, 1'b1)
		`CHK(wd, e)
		`CHK(fl, {n, z})
	endtask
	task end_sim;
		$display("tests %0d errors %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		#100000;
		fail_count++;
		end_sim;
	end
	// Reset, then the scenarios
	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		t_reg;
		t_idx;
		t_sym;
		t_abs;
		t_ind;
		t_inc;
		t_imm;
		t_cg;
		t_wb(1'b1, 16'hA300, 16'h0000, 1'b0, 1'b1);
		t_wb(1'b1, 16'h1280, 16'h0080, 1'b1, 1'b0);
		t_wb(1'b0, 16'h8000, 16'h8000, 1'b1, 1'b0);
		end_sim;
	end
endmodule
bind oau_top oau_monitor mon_u (.core_clk_i, .rstn_i, .start_i, .instr_i, .instr_ptr_i, .src_reg_val_i,
	.mem_ack_i, .wb_en_i, .wb_value_i, .mem_o, .busy_o, .result_o, .ptr_we_o, .ptr_reg_o, .ptr_val_o,
	.reg_we_o, .reg_wdata_o, .flags_o);
